// ==== pin_mux_consts.vh ====
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

// ==========================================================
// register bus
`define BUS_ADDR_W        32
`define BUS_DATA_W        32
`define BUS_BE_W          4
`define SEL_UPPER_ADDR    32'he002c004
`define READ_UNMAPPED     32'h00000000

// ==========================================================
// select register layout
`define SEL_UPPER_RESET   32'h15400000
`define SEL_UPPER_WMASK   32'h3fcfffff
`define FIELD_W           2
`define PIN_COUNT         16

// ==========================================================
// field encodings
`define ENC_GPIO          2'h0
`define ENC_FUNC1         2'h1
`define ENC_FUNC2         2'h2
`define ENC_FUNC3         2'h3

// ==========================================================
// pins that carry a gpio function at all
`define PIN_GPIO_MASK     16'h7bff
`define ANALOG_FIRST      11
`define ANALOG_COUNT      4
`define ANALOG_RESET      4'hf

// ==========================================================
// idle levels presented to peripheral inputs
`define IDLE_LOW          1'b0
`define IDLE_CAN          1'b1
`define IDLE_SSEL         1'b1

`endif

// ==== pin_select_register.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.vh"

module pin_select_register #(
  parameter [31:0] RESET_VALUE = `SEL_UPPER_RESET,
  parameter [31:0] WRITE_MASK  = `SEL_UPPER_WMASK
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        wrEn,
  input  wire [3:0]  byteEn,
  input  wire [31:0] wrData,
  output wire [31:0] value
);

  reg  [31:0] value_reg;
  reg  [31:0] value_next;
  integer     b;

  // reserved fields never take a written value, so they read zero
  always @* begin
    value_next = value_reg;
    if (wrEn) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (byteEn[b]) begin
          value_next[b*8 +: 8] = wrData[b*8 +: 8] & WRITE_MASK[b*8 +: 8];
        end
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule
`default_nettype wire

// ==== pad_function_cell.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.vh"

module pad_function_cell #(
  parameter GPIO_OK = 1
) (
  input  wire [1:0] sel,
  input  wire       gpioOut,
  input  wire       gpioDir,
  input  wire [2:0] funcOut,
  input  wire [2:0] funcOe,
  input  wire       padIn,
  output reg        padOut,
  output reg        padOe,
  output reg        gpioIn,
  output reg  [2:0] funcIn
);

  // only the chosen function sees or drives the pad
  always @* begin
    padOut = 1'b0;
    padOe  = 1'b0;
    gpioIn = 1'b0;
    funcIn = 3'h0;
    case (sel)
      `ENC_GPIO: begin
        if (GPIO_OK != 0) begin
          padOut = gpioOut;
          padOe  = gpioDir;
          gpioIn = padIn;
        end
      end
      `ENC_FUNC1: begin
        padOut    = funcOut[0];
        padOe     = funcOe[0];
        funcIn[0] = padIn;
      end
      `ENC_FUNC2: begin
        padOut    = funcOut[1];
        padOe     = funcOe[1];
        funcIn[1] = padIn;
      end
      `ENC_FUNC3: begin
        padOut    = funcOut[2];
        padOe     = funcOe[2];
        funcIn[2] = padIn;
      end
      default: begin
        padOut = 1'b0;
        padOe  = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ==== port0_upper_pin_function_mux.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.vh"

// Overview of operation
// - 32-bit select register, two bits per pin
// - 00 is gpio; pins 26, 31 reserved
// - pins 16-19 map interrupt, timer, serial functions
// - pins 20-22 map timer, select, pwm, interrupt
// - pin 23 code 01 feeds can2 receive
// - pin 24 code 01 drives can2 transmit
// - pin 25 code 01 feeds can1 receive
// - pins 27-30 map analog, capture, match, interrupt
// - reset selects analog on pins 27-30
// - gpio direction counts only in gpio mode
// - otherwise the function code fixes pad enable; serial pins 17-19 take the peripheral's
// - can3 on pins 21, 22 if built
// - one selected function owns the pad
module port0_upper_pin_function_mux #(
  parameter CAN3_PRESENT = 0
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [31:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  input  wire [15:0] port0Direction,
  input  wire [15:0] gpioOut,
  output reg  [15:0] gpioIn,
  input  wire [15:0] padIn,
  output reg  [15:0] padOut,
  output reg  [15:0] padOe,
  input  wire [3:0]  timerZeroMatch,
  output reg  [3:0]  timerZeroCapture,
  input  wire [3:2]  timerOneMatch,
  output reg  [3:2]  timerOneCapture,
  input  wire        serialOneSckOut,
  input  wire        serialOneSckOe,
  output reg         serialOneSckIn,
  input  wire        serialOneMisoOut,
  input  wire        serialOneMisoOe,
  output reg         serialOneMisoIn,
  input  wire        serialOneMosiOut,
  input  wire        serialOneMosiOe,
  output reg         serialOneMosiIn,
  output reg         serialOneSelectIn,
  output reg         externalInterrupt0,
  output reg         externalInterrupt3,
  input  wire        pwmOutput5,
  output reg         can1Receive,
  output reg         can2Receive,
  input  wire        can2Transmit,
  output reg         can3Receive,
  input  wire        can3Transmit,
  output reg  [3:0]  analogInputEnable
);

  localparam [0:0] CAN3_ON = (CAN3_PRESENT != 0) ? 1'b1 : 1'b0;

  wire [31:0] selValue;
  wire        addrHit;
  wire        regWrite;
  wire [15:0] enc1Out;
  wire [15:0] enc1Oe;
  wire [15:0] enc2Out;
  wire [15:0] enc2Oe;
  wire [15:0] enc3Out;
  wire [15:0] enc3Oe;
  wire [15:0] enc1In;
  wire [15:0] enc2In;
  wire [15:0] enc3In;
  wire [15:0] hit1;
  wire [15:0] hit2;
  wire [15:0] cellOut;
  wire [15:0] cellOe;
  wire [15:0] cellGpioIn;
  wire [3:0]  analogNext;
  wire [3:0]  zeroCapture_next;
  wire [3:2]  oneCapture_next;
  wire        interrupt3_next;

  // ==========================================================
  // avalon slave
  // one wait cycle per access; waitrequest rests high when idle
  assign addrHit  = (address == `SEL_UPPER_ADDR);
  assign regWrite = write & ~waitrequest & addrHit;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if (waitrequest && (read || write)) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= `READ_UNMAPPED;
    end else if (read && waitrequest) begin
      readdata <= addrHit ? selValue : `READ_UNMAPPED;
    end
  end

  // ==========================================================
  // select register
  // byte-lane storage
  pin_select_register #(
    .RESET_VALUE (`SEL_UPPER_RESET),
    .WRITE_MASK  (`SEL_UPPER_WMASK)
  ) u_select (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (regWrite),
    .byteEn (byteenable),
    .wrData (writedata),
    .value  (selValue)
  );

  // ==========================================================
  // per-encoding drive, index is pin minus 16
  // outputs on code 01
  // can3 transmit gated by build option
  assign enc1Out = {
    1'b0,                       // 31
    1'b0,                       // 30 analog
    1'b0,                       // 29 analog
    1'b0,                       // 28 analog
    1'b0,                       // 27 analog
    1'b0,                       // 26
    1'b0,                       // 25
    can2Transmit,               // 24
    1'b0,                       // 23
    can3Transmit & CAN3_ON,     // 22
    pwmOutput5,                 // 21
    timerOneMatch[3],           // 20
    timerOneMatch[2],           // 19
    1'b0,                       // 18
    1'b0,                       // 17
    1'b0                        // 16
  };
  assign enc1Oe = {
    1'b0,                       // 31
    1'b0,                       // 30 analog
    1'b0,                       // 29 analog
    1'b0,                       // 28 analog
    1'b0,                       // 27 analog
    1'b0,                       // 26
    1'b0,                       // 25 input only
    1'b1,                       // 24
    1'b0,                       // 23 input only
    CAN3_ON,                    // 22
    1'b1,                       // 21
    1'b1,                       // 20
    1'b1,                       // 19
    1'b0,                       // 18 capture
    1'b0,                       // 17 capture
    1'b0                        // 16 interrupt
  };

  // serial lines and match on code 10
  assign enc2Out = {
    1'b0,                       // 31
    1'b0,                       // 30 interrupt
    1'b0,                       // 29 capture
    1'b0,                       // 28 capture
    1'b0,                       // 27 capture
    1'b0,                       // 26
    1'b0,                       // 25
    1'b0,                       // 24
    1'b0,                       // 23
    1'b0,                       // 22 capture
    1'b0,                       // 21 can3 receive
    1'b0,                       // 20 select input
    serialOneMosiOut,           // 19
    serialOneMisoOut,           // 18
    serialOneSckOut,            // 17
    timerZeroMatch[2]           // 16
  };
  // serial port owns its own enables
  assign enc2Oe = {
    1'b0,                       // 31
    1'b0,                       // 30 interrupt
    1'b0,                       // 29 capture
    1'b0,                       // 28 capture
    1'b0,                       // 27 capture
    1'b0,                       // 26
    1'b0,                       // 25
    1'b0,                       // 24
    1'b0,                       // 23
    1'b0,                       // 22 capture
    1'b0,                       // 21 can3 receive
    1'b0,                       // 20 select input
    serialOneMosiOe,            // 19
    serialOneMisoOe,            // 18
    serialOneSckOe,             // 17
    1'b1                        // 16
  };

  assign enc3Out = {
    1'b0,                       // 31
    1'b0,                       // 30
    timerZeroMatch[3],          // 29
    timerZeroMatch[2],          // 28
    timerZeroMatch[1],          // 27
    1'b0,                       // 26
    1'b0,                       // 25
    1'b0,                       // 24
    1'b0,                       // 23
    timerZeroMatch[0],          // 22
    1'b0,                       // 21
    1'b0,                       // 20
    timerOneMatch[3],           // 19
    timerOneMatch[3],           // 18
    timerOneMatch[2],           // 17
    1'b0                        // 16
  };
  assign enc3Oe = {
    1'b0,                       // 31
    1'b0,                       // 30 capture
    1'b1,                       // 29
    1'b1,                       // 28
    1'b1,                       // 27
    1'b0,                       // 26
    1'b0,                       // 25
    1'b0,                       // 24
    1'b0,                       // 23
    1'b1,                       // 22
    1'b0,                       // 21 capture
    1'b0,                       // 20 interrupt
    1'b1,                       // 19
    1'b1,                       // 18
    1'b1,                       // 17
    1'b0                        // 16 capture
  };

  // ==========================================================
  // pad cells
  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i = i + 1) begin : g_pad
      assign hit1[i] = selValue[i*`FIELD_W +: `FIELD_W] == `ENC_FUNC1;
      assign hit2[i] = selValue[i*`FIELD_W +: `FIELD_W] == `ENC_FUNC2;
      pad_function_cell #(
        .GPIO_OK (`PIN_GPIO_MASK >> i & 1)
      ) u_cell (
        .sel     (selValue[i*`FIELD_W +: `FIELD_W]),
        .gpioOut (gpioOut[i]),
        .gpioDir (port0Direction[i]),
        .funcOut ({enc3Out[i], enc2Out[i], enc1Out[i]}),
        .funcOe  ({enc3Oe[i], enc2Oe[i], enc1Oe[i]}),
        .padIn   (padIn[i]),
        .padOut  (cellOut[i]),
        .padOe   (cellOe[i]),
        .gpioIn  (cellGpioIn[i]),
        .funcIn  ({enc3In[i], enc2In[i], enc1In[i]})
      );
    end
  endgenerate

  // analog mode disables the digital drive
  // the converter is enabled only while the field holds code 01,
  // which also keeps every digital driver off it
  assign analogNext = hit1[`ANALOG_FIRST +: `ANALOG_COUNT];

  // ==========================================================
  // shared peripheral inputs
  // an unselected pin adds zero, so a plain or needs no priority
  // timerZeroCapture[0], [2], timerOneCapture[3] and interrupt 3 fed from two pins
  assign zeroCapture_next[0] = enc2In[6] | enc3In[14];
  assign zeroCapture_next[1] = enc2In[11];
  assign zeroCapture_next[2] = enc3In[0] | enc2In[12];
  assign zeroCapture_next[3] = enc2In[13];
  assign oneCapture_next[2]  = enc1In[1];
  assign oneCapture_next[3]  = enc1In[2] | enc3In[5];
  assign interrupt3_next     = enc3In[4] | enc2In[14];

  // ==========================================================
  // registered pad side
  // one flop stage keeps the pads free of select-decode glitches
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      padOut <= 16'h0000;
      padOe  <= 16'h0000;
      gpioIn <= 16'h0000;
    end else begin
      padOut <= cellOut;
      padOe  <= cellOe;
      gpioIn <= cellGpioIn;
    end
  end

  // ==========================================================
  // registered peripheral inputs
  // a reserved code leaves every fed input at its idle level
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timerZeroCapture   <= 4'h0;
      timerOneCapture    <= 2'h0;
      serialOneSckIn     <= `IDLE_LOW;
      serialOneMisoIn    <= `IDLE_LOW;
      serialOneMosiIn    <= `IDLE_LOW;
      serialOneSelectIn  <= `IDLE_SSEL;
      externalInterrupt0 <= `IDLE_LOW;
      externalInterrupt3 <= `IDLE_LOW;
      can1Receive        <= `IDLE_CAN;
      can2Receive        <= `IDLE_CAN;
      can3Receive        <= `IDLE_CAN;
      analogInputEnable  <= `ANALOG_RESET;
    end else begin
      timerZeroCapture <= zeroCapture_next;
      timerOneCapture  <= oneCapture_next;
      serialOneSckIn  <= enc2In[1];
      serialOneMisoIn <= enc2In[2];
      serialOneMosiIn <= enc2In[3];
      serialOneSelectIn <= hit2[4] ? enc2In[4] : `IDLE_SSEL;
      externalInterrupt0 <= enc1In[0];
      externalInterrupt3 <= interrupt3_next;
      can2Receive <= hit1[7] ? enc1In[7] : `IDLE_CAN;
      can1Receive <= hit1[9] ? enc1In[9] : `IDLE_CAN;
      can3Receive <= (hit2[5] && CAN3_ON) ? enc2In[5] : `IDLE_CAN;
      analogInputEnable <= analogNext;
    end
  end

endmodule
`default_nettype wire

// ==== port0_mux_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.vh"
module port0_mux_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] address,
  input wire logic        waitrequest,
  input wire logic [31:0] readdata,
  input wire logic [15:0] port0Direction,
  input wire logic [15:0] padIn,
  input wire logic [15:0] padOe,
  input wire logic [15:0] gpioIn,
  input wire logic        can1Receive,
  input wire logic        can2Receive,
  input wire logic        externalInterrupt0,
  input wire logic [3:0]  analogInputEnable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ====================================================
  // bus handshake
  sequence taken_s;
    (read || write) && waitrequest;
  endsequence
  sequence answer_s;
    !waitrequest ##1 waitrequest;
  endsequence
  one_wait_a: assert property (taken_s |=> answer_s)
    else $error("wait cycle wrong");
  unmapped_zero_a: assert property (
    taken_s ##0 (read && address != `SEL_UPPER_ADDR) |=> readdata == 32'h0)
    else $error("unmapped read not zero");
  reserved_bits_a: assert property (
    read && !waitrequest |->
      readdata[21:20] == 2'h0 && readdata[31:30] == 2'h0)
    else $error("reserved field reads nonzero");
  // ====================================================
  // pad and peripheral side
  dead_pins_a: assert property (
    padOe[10] == 1'b0 && padOe[15] == 1'b0 &&
      gpioIn[10] == 1'b0 && gpioIn[15] == 1'b0)
    else $error("pin 26 or 31 active");
  input_only_a: assert property (
    padOe[7] || padOe[9] |->
      $past(port0Direction[7]) || $past(port0Direction[9]))
    else $error("input pin driven");
  analog_float_a: assert property (
    (analogInputEnable & padOe[14:11]) == 4'h0)
    else $error("analog pin driven");
  // register lands at the write's last edge, enables follow one edge on
  analog_hold_a: assert property (
    $changed(analogInputEnable) |-> $past(write, 2))
    else $error("analog enable moved alone");
  can2_source_a: assert property (!can2Receive |-> !$past(padIn[7]))
    else $error("can2 receive not from pin 23");
  can1_source_a: assert property (!can1Receive |-> !$past(padIn[9]))
    else $error("can1 receive not from pin 25");
  external_interrupt_0_source_a: assert property (
    externalInterrupt0 |-> $past(padIn[0]))
    else $error("interrupt 0 not from pin 16");
endmodule
bind port0_upper_pin_function_mux port0_mux_properties i_props (.clk, .rst,
  .read, .write, .address, .waitrequest, .readdata, .port0Direction, .padIn,
  .padOe, .gpioIn, .can1Receive, .can2Receive, .externalInterrupt0,
  .analogInputEnable);
`default_nettype wire

// ==== periph_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input  wire logic       lvl,
  output wire logic [3:0] timerZeroMatch,
  output wire logic [3:2] timerOneMatch,
  output wire logic       serialOneSckOut,
  output wire logic       serialOneSckOe,
  output wire logic       serialOneMisoOut,
  output wire logic       serialOneMisoOe,
  output wire logic       serialOneMosiOut,
  output wire logic       serialOneMosiOe,
  output wire logic       pwmOutput5,
  output wire logic       can2Transmit,
  output wire logic       can3Transmit
);
  // ====================================================
  // sources
  // neighbours differ so a wrong route shows at the pad
  assign timerZeroMatch = {~lvl, lvl, ~lvl, lvl};
  assign timerOneMatch = {lvl, ~lvl};
  assign serialOneSckOut = lvl;
  assign serialOneMisoOut = ~lvl;
  assign serialOneMosiOut = lvl;
  assign serialOneSckOe = 1'b1;
  assign serialOneMisoOe = 1'b1;
  assign serialOneMosiOe = 1'b1;
  assign pwmOutput5 = lvl;
  assign can2Transmit = ~lvl;
  assign can3Transmit = lvl;
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst, read, write, waitrequest, lvl;
  logic        serialOneSckOut, serialOneSckOe, serialOneSckIn;
  logic        serialOneMisoOut, serialOneMisoOe, serialOneMisoIn;
  logic        serialOneMosiOut, serialOneMosiOe, serialOneMosiIn;
  logic        serialOneSelectIn, externalInterrupt0, externalInterrupt3;
  logic        pwmOutput5, can1Receive, can2Receive, can3Receive;
  logic        can2Transmit, can3Transmit;
  logic [31:0] address, writedata, readdata, q;
  logic [3:0]  byteenable, timerZeroMatch, timerZeroCapture;
  logic [3:0]  analogInputEnable;
  logic [3:2]  timerOneMatch, timerOneCapture;
  logic [15:0] port0Direction, gpioOut, gpioIn, padIn, padOut, padOe;
  logic [15:0] padOutB, padOeB;
  logic        can3ReceiveB;
  integer      failures, compares;
  port0_upper_pin_function_mux i_dut (.*);
  periph_model i_peri (.*);
  // second copy built with can3 routing for the optional codes
  port0_upper_pin_function_mux #(.CAN3_PRESENT(1)) i_dut_can3 (
    .clk, .rst, .address, .read, .write, .writedata, .byteenable,
    .readdata (), .waitrequest (), .port0Direction, .gpioOut,
    .gpioIn (), .padIn, .padOut (padOutB), .padOe (padOeB),
    .timerZeroMatch, .timerZeroCapture (), .timerOneMatch,
    .timerOneCapture (), .serialOneSckOut, .serialOneSckOe,
    .serialOneSckIn (), .serialOneMisoOut, .serialOneMisoOe,
    .serialOneMisoIn (), .serialOneMosiOut, .serialOneMosiOe,
    .serialOneMosiIn (), .serialOneSelectIn (), .externalInterrupt0 (),
    .externalInterrupt3 (), .pwmOutput5, .can1Receive (), .can2Receive (),
    .can2Transmit, .can3Receive (can3ReceiveB), .can3Transmit,
    .analogInputEnable ()
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ====================================================
  // helpers
  task complete_run;
    begin
      if (failures == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    integer n;
    begin
      address <= a;
      writedata <= d;
      write <= w;
      read <= ~w;
      n = 0;
      @(posedge clk);
      while (waitrequest !== 1'b0) begin
        n = n + 1;
        if (n > 16) begin
          failures = failures + 1;
          complete_run;
        end
        @(posedge clk);
      end
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    begin
      acc(1'b0, a, 32'h0);
      chk(q, exp);
    end
  endtask
  // ====================================================
  // sequence
  initial begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 32'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    lvl = 1'b1;
    port0Direction = 16'hffff;
    gpioOut = 16'h5555;
    padIn = 16'h0001;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(32'he002c004, 32'h15400000);
    chk(analogInputEnable, 4'hf);
    chk(padOe, 16'h03ff);
    chk(padOut, 16'h0155);
    acc(1'b1, 32'he002c004, 32'hffffffff);
    rd(32'he002c004, 32'h3fcfffff);
    acc(1'b1, 32'he002c000, 32'h0);
    rd(32'he002c004, 32'h3fcfffff);
    rd(32'he002c000, 32'h0);
    port0Direction <= 16'h0;
    padIn <= 16'h4020;
    repeat (2) @(posedge clk);
    chk(padOe, 16'h384e);
    chk(padOut, 16'h104c);
    chk(timerOneCapture, 2'h2);
    chk(timerZeroCapture, 4'h1);
    chk(externalInterrupt3, 1'b0);
    chk(can2Receive, 1'b1);
    chk(gpioIn, 16'h0);
    lvl <= 1'b0;
    repeat (2) @(posedge clk);
    chk(padOut, 16'h2802);
    acc(1'b1, 32'he002c004, 32'haaaaaaaa);
    rd(32'he002c004, 32'h2a8aaaaa);
    padIn <= 16'h680a;
    repeat (2) @(posedge clk);
    chk(padOe, 16'h000f);
    chk(padOut, 16'h0004);
    chk(serialOneSelectIn, 1'b0);
    chk(externalInterrupt3, 1'b1);
    chk(timerZeroCapture, 4'ha);
    chk(can3Receive, 1'b1);
    chk(can3ReceiveB, 1'b0);
    chk({serialOneSckIn, serialOneMisoIn, serialOneMosiIn}, 3'h5);
    chk(timerOneCapture, 2'h0);
    lvl <= 1'b1;
    padIn <= 16'h0005;
    acc(1'b1, 32'he002c004, 32'h55555555);
    repeat (2) @(posedge clk);
    chk(padOe, 16'h0138);
    chk(padOut, 16'h0030);
    chk(padOeB, 16'h0178);
    chk(padOutB, 16'h0070);
    chk(externalInterrupt0, 1'b1);
    chk(timerOneCapture, 2'h2);
    chk(can2Receive, 1'b0);
    chk(can1Receive, 1'b0);
    chk(analogInputEnable, 4'hf);
    lvl <= 1'b0;
    repeat (2) @(posedge clk);
    chk(padOut, 16'h0108);
    byteenable <= 4'h1;
    acc(1'b1, 32'he002c004, 32'h0);
    rd(32'he002c004, 32'h15455500);
    byteenable <= 4'hf;
    acc(1'b1, 32'he002c004, 32'h0);
    port0Direction <= 16'h84f0;
    padIn <= 16'h9634;
    repeat (2) @(posedge clk);
    chk(padOe, 16'h00f0);
    chk(padOut & padOe, 16'h0050);
    chk(gpioIn, 16'h1234);
    chk(analogInputEnable, 4'h0);
    complete_run;
  end
endmodule
`default_nettype wire
